// ---- rtl/ptp_pkg.sv ----
package ptp_pkg;
  localparam int CW = 16;
  localparam int CFRAC = 12;
  localparam int IW = 24;
  localparam int IFRAC = 8;
  localparam int TW = 4 * CW;
  localparam int NTAB = 11;
  localparam int T_RMAP = 0;
  localparam int T_I2C = 4;
  localparam int T_I2I = 8;
  localparam int T_S2S = 9;
  localparam int T_CTAB = 10;
  localparam int SC_DEPTH = 4;
  localparam logic signed [CW-1:0] C_ONE = 16'sh1000;
  localparam logic signed [CW-1:0] C_MAX = 16'sh7fff;
  localparam logic signed [CW-1:0] C_MIN = 16'sh8000;
  localparam logic [CW-1:0] C_HALF = 16'h0800;
  localparam logic [IW-1:0] I_HALF = 24'h00_0080;
  localparam logic CTAB_EN_RST = 1'b0;

  typedef enum logic [2:0] {K_FCOL, K_ICOL, K_DEPTH, K_CIDX, K_SIDX, K_DS} ptp_kind_t;
  typedef enum logic [2:0] {
    FMT_ALPHA, FMT_LUM, FMT_LUM_ALPHA, FMT_INTENS, FMT_RGB, FMT_RGBA
  } ptp_fmt_t;

  // c[0] doubles as the depth value; idx is fixed point with IFRAC fraction bits
  typedef struct packed {
    ptp_kind_t kind;
    logic idx_int;
    logic [3:0][CW-1:0] c;
    logic [IW-1:0] idx;
  } ptp_grp_t;

  // signed multiply then signed add, saturated rather than wrapped
  function automatic logic [CW-1:0] scale_bias(input logic signed [CW-1:0] v,
                                               input logic signed [CW-1:0] s,
                                               input logic signed [CW-1:0] b);
    logic signed [2*CW-1:0] p;
    p = v * s;
    p = (p >>> CFRAC) + (2*CW)'(b);
    if (p > (2*CW)'(C_MAX)) return C_MAX;
    if (p < (2*CW)'(C_MIN)) return C_MIN;
    return p[CW-1:0];
  endfunction : scale_bias

  function automatic logic [CW-1:0] size_m1(input logic [3:0] n);
    return CW'((32'd1 << n) - 32'd1);
  endfunction : size_m1

  // clamp to [0,1], scale by entries minus one, round to nearest
  function automatic logic [CW-1:0] comp_addr(input logic signed [CW-1:0] v,
                                              input logic [CW-1:0] m1);
    logic [CFRAC:0] cl;
    logic [CFRAC+CW:0] p;
    if (v < 0) cl = '0;
    else if (v > C_ONE) cl = C_ONE[CFRAC:0];
    else cl = v[CFRAC:0];
    p = (CFRAC+CW+1)'(cl) * (CFRAC+CW+1)'(m1) + (CFRAC+CW+1)'(C_HALF);
    return p[CFRAC+CW-1:CFRAC];
  endfunction : comp_addr

  function automatic logic [CW-1:0] idx_addr(input logic [IW-1:0] x,
                                             input logic [3:0] n,
                                             input logic rnd);
    logic [IW-1:0] r;
    r = rnd ? x + I_HALF : x;
    return r[IW-1:IFRAC] & size_m1(n);
  endfunction : idx_addr

  function automatic logic [3:0] ct_mask(input ptp_fmt_t f);
    unique case (f)
      FMT_ALPHA: return 4'h8;
      FMT_LUM, FMT_RGB: return 4'h7;
      FMT_LUM_ALPHA, FMT_INTENS, FMT_RGBA: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction : ct_mask

  function automatic logic [1:0] ct_slot(input ptp_fmt_t f, input logic [1:0] ch);
    if (f == FMT_INTENS) return 2'd0;
    if (f == FMT_LUM || f == FMT_LUM_ALPHA) return (ch == 2'd3) ? 2'd3 : 2'd0;
    return ch;
  endfunction : ct_slot
endpackage : ptp_pkg

// ---- rtl/ptp_wr_if.sv ----
`timescale 1ns/10ps
interface ptp_wr_if #(parameter int AW = 8);
  logic [ptp_pkg::NTAB-1:0] we;
  logic [AW-1:0] addr;
  logic [ptp_pkg::TW-1:0] data;
  modport drv (output we, output addr, output data);
  modport lut (input we, input addr, input data);
endinterface : ptp_wr_if

// ---- rtl/ptp_fifo.sv ----
`timescale 1ns/10ps
module ptp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic room;
    logic nempty;
  } ptp_fifo_st_t;

  ptp_fifo_st_t st_q, st_d;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  assign push = in_valid && st_q.room;
  assign pop = st_q.nempty && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = st_q.wp + PW'(1);
    if (pop) st_d.rp = st_q.rp + PW'(1);
    st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    // flags kept in flops so ready and valid leave without logic
    st_d.room = (st_d.cnt != (PW+1)'(DEPTH));
    st_d.nempty = (st_d.cnt != '0);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.room <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[st_q.wp] <= in_data;
  end

  assign in_ready = st_q.room;
  assign out_valid = st_q.nempty;
  assign out_data = mem[st_q.rp];
endmodule : ptp_fifo

// ---- rtl/ptp_lut.sv ----
`timescale 1ns/10ps
module ptp_lut #(
  parameter int W = 16,
  parameter int AW = 8,
  parameter int RP = 1,
  parameter int ID = 0
) (
  input wire logic clk,
  ptp_wr_if.lut wr,
  input wire logic [RP-1:0][AW-1:0] raddr,
  output logic [RP-1:0][W-1:0] rdata
);
  logic [W-1:0] mem [2**AW];

  if (W > ptp_pkg::TW || ID >= ptp_pkg::NTAB || RP < 1) begin : g_chk
    $error("lookup table parameters out of range");
  end

  // no reset: contents are undefined until host software loads them
  always_ff @(posedge clk) begin
    if (wr.we[ID]) mem[wr.addr] <= wr.data[W-1:0];
  end

  always_comb begin
    for (int p = 0; p < RP; p++) rdata[p] = mem[raddr[p]];
  end
endmodule : ptp_lut

// ---- rtl/ptp_pipe.sv ----
`timescale 1ns/10ps
// How it works
// (RULE1) every group carries one of six kind tags
// (RULE2) steps run in turn; a step not meant for a kind passes it unchanged
// (RULE3) integer colour quads leave every step bit-exact
// (RULE4) float colour and depth get signed scale then signed bias per component
// (RULE5) indices are fixed point with enough integer bits; integer indices zero fraction
// (RULE6) index shifted left by positive setting, right otherwise, zero filled
// (RULE7) signed offset added to every colour and stencil index after shift
// (RULE8) colour mapping clamps each float component, then per-channel table lookup
// (RULE9) map address is clamped value times size minus one, rounded
// (RULE10) colour index becomes colour quad when destination needs quads
// (RULE11) conversion rounds, masks per table, fetches red, green, blue, alpha
// (RULE12) otherwise with mapping on, index-to-index table replaces the index
// (RULE13) stencil mapping masks integer stencil and replaces it from its table
// (RULE14) colour table only when enabled; zero-width table means no lookup
// (RULE15) table format picks which channels are replaced
// (RULE16) replaced channel clamped, times width minus one, rounded, then looked up
// (RULE17) colour table enable is one state bit, reset to disabled
// (RULE18) fixed step order; one group per cycle under valid/ready
// (RULE19) host loads power-of-two tables first and leaves them alone in flight
module ptp_pipe #(
  parameter int AW = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire ptp_pkg::ptp_grp_t in_grp,
  output logic out_valid,
  input wire logic out_ready,
  output ptp_pkg::ptp_grp_t out_grp,
  input wire logic [4:0][ptp_pkg::CW-1:0] scale,
  input wire logic [4:0][ptp_pkg::CW-1:0] bias,
  input wire logic signed [5:0] idx_shift,
  input wire logic [15:0] idx_offset,
  input wire logic map_color,
  input wire logic map_stencil,
  input wire logic need_rgba,
  input wire logic ctab_enable,
  input wire ptp_pkg::ptp_fmt_t ctab_format,
  input wire logic [AW:0] ctab_width,
  input wire logic [ptp_pkg::NTAB-2:0][3:0] map_log2,
  input wire logic tbl_we,
  input wire logic [3:0] tbl_sel,
  input wire logic [AW-1:0] tbl_addr,
  input wire logic [ptp_pkg::TW-1:0] tbl_wdata
);
  localparam int CW = ptp_pkg::CW;
  localparam int IW = ptp_pkg::IW;
  localparam int IFRAC = ptp_pkg::IFRAC;

  typedef struct packed {
    logic v1;
    ptp_pkg::ptp_grp_t g1;
    logic v2;
    ptp_pkg::ptp_grp_t g2;
    logic ctab_en;
  } ptp_st_t;

  ptp_st_t st_q, st_d;
  logic f_valid, adv1, adv2;
  ptp_pkg::ptp_grp_t f_grp, mid;
  logic [ptp_pkg::NTAB-2:0][AW-1:0] ra;
  logic [ptp_pkg::NTAB-2:0][CW-1:0] rd;
  logic [3:0][AW-1:0] cta;
  logic [3:0][ptp_pkg::TW-1:0] ctd;

  ptp_wr_if #(.AW(AW)) wr ();

  // integer part of an index must cover the largest table
  if (AW < 1 || AW > IW - IFRAC - 1 || IW - IFRAC != 16) begin : g_chk // RULE5
    $error("table address width does not fit the index format");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input buffer and tables

  ptp_fifo #(.W($bits(ptp_pkg::ptp_grp_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_grp),
    .out_valid(f_valid),
    .out_ready(adv1),
    .out_data(f_grp)
  );

  always_comb begin
    for (int t = 0; t < ptp_pkg::NTAB; t++) wr.we[t] = tbl_we && (tbl_sel == 4'(t));
  end
  assign wr.addr = tbl_addr;
  assign wr.data = tbl_wdata;

  for (genvar t = 0; t < ptp_pkg::NTAB - 1; t++) begin : g_tab
    ptp_lut #(.W(CW), .AW(AW), .RP(1), .ID(t)) u_tab (
      .clk(clk),
      .wr(wr.lut),
      .raddr(ra[t]),
      .rdata(rd[t])
    );
  end

  // four read ports so every channel looks up in the same cycle
  ptp_lut #(.W(ptp_pkg::TW), .AW(AW), .RP(4), .ID(ptp_pkg::T_CTAB)) u_ctab (
    .clk(clk),
    .wr(wr.lut),
    .raddr(cta),
    .rdata(ctd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // stage two lookups, addresses taken from stage one

  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      ra[ptp_pkg::T_RMAP+ch] = AW'(ptp_pkg::comp_addr(st_q.g1.c[ch],
                                  ptp_pkg::size_m1(map_log2[ptp_pkg::T_RMAP+ch]))); // RULE9
      ra[ptp_pkg::T_I2C+ch] = AW'(ptp_pkg::idx_addr(st_q.g1.idx,
                                  map_log2[ptp_pkg::T_I2C+ch], 1'b1)); // RULE11
    end
    ra[ptp_pkg::T_I2I] = AW'(ptp_pkg::idx_addr(st_q.g1.idx,
                             map_log2[ptp_pkg::T_I2I], 1'b1)); // RULE12
    // stencil uses the integer part as is, no rounding
    ra[ptp_pkg::T_S2S] = AW'(ptp_pkg::idx_addr(st_q.g1.idx,
                             map_log2[ptp_pkg::T_S2S], 1'b0)); // RULE13
  end

  always_comb begin
    mid = st_q.g1;
    unique case (st_q.g1.kind)
      ptp_pkg::K_FCOL: begin
        if (map_color) begin // RULE8
          for (int ch = 0; ch < 4; ch++) mid.c[ch] = rd[ptp_pkg::T_RMAP+ch];
        end
      end
      ptp_pkg::K_CIDX: begin
        if (need_rgba) begin // RULE10
          mid.kind = ptp_pkg::K_FCOL;
          for (int ch = 0; ch < 4; ch++) mid.c[ch] = rd[ptp_pkg::T_I2C+ch]; // RULE11
        end else if (map_color) begin
          mid.idx = {rd[ptp_pkg::T_I2I], {IFRAC{1'b0}}}; // RULE12
        end
      end
      ptp_pkg::K_SIDX, ptp_pkg::K_DS: begin
        if (map_stencil) mid.idx = {rd[ptp_pkg::T_S2S], {IFRAC{1'b0}}}; // RULE13
      end
      ptp_pkg::K_ICOL, ptp_pkg::K_DEPTH: begin
        mid = st_q.g1; // RULE3
      end
      default: begin
        mid = st_q.g1;
      end
    endcase
  end

  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      cta[ch] = AW'(ptp_pkg::comp_addr(mid.c[ch], CW'(ctab_width) - 16'h0001)); // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pipeline state

  // a full stage may still load when the one after it drains this cycle
  assign adv2 = !st_q.v2 || out_ready; // RULE18
  assign adv1 = !st_q.v1 || adv2; // RULE18

  always_comb begin
    ptp_pkg::ptp_grp_t g;
    logic [IW-1:0] x;
    logic [5:0] mag;
    logic [3:0] msk;
    g = f_grp;
    x = '0;
    mag = '0;
    msk = ptp_pkg::ct_mask(ctab_format); // RULE15
    st_d = st_q;
    st_d.ctab_en = ctab_enable; // RULE17
    if (adv1) begin
      st_d.v1 = f_valid;
      unique case (f_grp.kind) // RULE1
        ptp_pkg::K_FCOL: begin
          for (int ch = 0; ch < 4; ch++) begin
            g.c[ch] = ptp_pkg::scale_bias(f_grp.c[ch], scale[ch], bias[ch]); // RULE4
          end
        end
        ptp_pkg::K_DEPTH, ptp_pkg::K_DS: begin
          g.c[0] = ptp_pkg::scale_bias(f_grp.c[0], scale[ptp_pkg::SC_DEPTH],
                                       bias[ptp_pkg::SC_DEPTH]); // RULE4
        end
        default: begin
          g = f_grp; // RULE2
        end
      endcase
      if (f_grp.kind inside {ptp_pkg::K_CIDX, ptp_pkg::K_SIDX, ptp_pkg::K_DS}) begin
        x = f_grp.idx;
        if (f_grp.idx_int) x[IFRAC-1:0] = '0; // RULE5
        mag = idx_shift[5] ? 6'(-idx_shift) : idx_shift;
        x = (idx_shift > 0) ? (x << mag) : (x >> mag); // RULE6
        g.idx = x + {idx_offset, {IFRAC{1'b0}}}; // RULE7
      end
      st_d.g1 = g;
    end
    if (adv2) begin
      st_d.v2 = st_q.v1;
      g = mid;
      // a zero-width table has no entry to address
      if (st_q.ctab_en && ctab_width != '0 && mid.kind == ptp_pkg::K_FCOL) begin // RULE14
        for (int ch = 0; ch < 4; ch++) begin
          if (msk[ch]) begin
            g.c[ch] = ctd[ch][ptp_pkg::ct_slot(ctab_format, 2'(ch)) * CW +: CW]; // RULE16
          end
        end
      end
      st_d.g2 = g;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.ctab_en <= ptp_pkg::CTAB_EN_RST; // RULE17
    end else begin
      st_q <= st_d;
    end
  end

  assign out_valid = st_q.v2;
  assign out_grp = st_q.g2;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic ld1, ld2;
  assign ld1 = adv1 && f_valid;
  assign ld2 = adv2 && st_q.v1;

  a_icol_stage1: assert property ( // RULE3
    ld1 && f_grp.kind == ptp_pkg::K_ICOL |=> st_q.g1 == $past(f_grp))
    else $error("integer quad altered in stage one");

  a_icol_stage2: assert property ( // RULE3
    ld2 && st_q.g1.kind == ptp_pkg::K_ICOL |=> st_q.g2 == $past(st_q.g1))
    else $error("integer quad altered in stage two");

  a_depth_passes: assert property ( // RULE2
    ld2 && st_q.g1.kind == ptp_pkg::K_DEPTH |=> st_q.g2 == $past(st_q.g1))
    else $error("depth group altered by lookups");

  a_depth_unity: assert property ( // RULE4
    ld1 && f_grp.kind == ptp_pkg::K_DEPTH && scale[4] == ptp_pkg::C_ONE && bias[4] == '0
    |=> st_q.g1.c[0] == $past(f_grp.c[0]))
    else $error("unity scale and zero bias changed depth");

  a_int_frac_zero: assert property ( // RULE5
    ld1 && f_grp.kind == ptp_pkg::K_SIDX && f_grp.idx_int && idx_shift == '0
    |=> st_q.g1.idx[IFRAC-1:0] == '0)
    else $error("integer index gained fraction bits");

  a_index_offset: assert property ( // RULE7
    ld1 && f_grp.kind == ptp_pkg::K_CIDX && !f_grp.idx_int && idx_shift == '0
    |=> st_q.g1.idx == IW'($past(f_grp.idx) + {$past(idx_offset), {IFRAC{1'b0}}}))
    else $error("index offset not added");

  a_cidx_to_quad: assert property ( // RULE10
    ld2 && st_q.g1.kind == ptp_pkg::K_CIDX && need_rgba |=> st_q.g2.kind == ptp_pkg::K_FCOL)
    else $error("colour index not converted to quad");

  a_cidx_stays: assert property ( // RULE12
    ld2 && st_q.g1.kind == ptp_pkg::K_CIDX && !need_rgba |=> st_q.g2.kind == ptp_pkg::K_CIDX)
    else $error("colour index changed kind");

  a_stencil_bypass: assert property ( // RULE13
    ld2 && st_q.g1.kind == ptp_pkg::K_SIDX && !map_stencil
    |=> st_q.g2.idx == $past(st_q.g1.idx))
    else $error("stencil changed with mapping off");

  a_no_ctab_lookup: assert property ( // RULE14
    ld2 && st_q.g1.kind == ptp_pkg::K_FCOL && !map_color
    && (!st_q.ctab_en || ctab_width == '0) |=> st_q.g2.c == $past(st_q.g1.c))
    else $error("colour table applied while off or zero width");

  a_ctab_enable_bit: assert property ( // RULE17
    $fell(ctab_enable) ##1 ld2 && st_q.g1.kind == ptp_pkg::K_FCOL && !map_color
    |=> st_q.g2.c == $past(st_q.g1.c))
    else $error("colour table still on after disable");

  a_out_hold: assert property ( // RULE18
    out_valid && !out_ready |=> out_valid && $stable(out_grp))
    else $error("output changed while stalled");

  c_icol_through: cover property (ld2 && st_q.g1.kind == ptp_pkg::K_ICOL);
  c_cidx_convert: cover property (ld2 && st_q.g1.kind == ptp_pkg::K_CIDX && need_rgba);
  c_ctab_lookup: cover property (ld2 && st_q.ctab_en && mid.kind == ptp_pkg::K_FCOL);
  c_stall_full: cover property (out_valid && !out_ready && !in_ready);
endmodule : ptp_pipe

// ---- sim/ptp_sink.sv ----
`timescale 1ns/10ps
// downstream stage stand-in: takes groups, stalls as the bench asks
module ptp_sink (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] stall,
  output logic out_ready
);
  // moves on the falling edge so the pipe sees it settled at the rising edge
  always @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'h0;
    end else begin
      out_ready <= stall == 2'h0 || (stall == 2'h1 && $urandom_range(0, 2) != 0);
    end
  end
endmodule : ptp_sink

// ---- sim/pixel_transfer_pipeline_test.sv ----
`timescale 1ns/10ps
module pixel_transfer_pipeline_test;
  logic clk = 1'h0, reset_n = 1'h0, in_valid = 1'h0, in_ready, out_valid, out_ready;
  ptp_pkg::ptp_grp_t in_grp = '0, out_grp, g;
  logic [4:0][15:0] scale = '0, bias = '0;
  logic signed [5:0] idx_shift = '0;
  logic [15:0] idx_offset = '0;
  logic map_color = 1'h0, map_stencil = 1'h0, need_rgba = 1'h0, ctab_enable = 1'h0;
  ptp_pkg::ptp_fmt_t ctab_format = ptp_pkg::FMT_RGBA;
  logic [8:0] ctab_width = '0;
  logic [9:0][3:0] map_log2 = '0;
  logic tbl_we = 1'h0;
  logic [3:0] tbl_sel = '0;
  logic [7:0] tbl_addr = '0;
  logic [63:0] tbl_wdata = '0;
  logic [1:0] stall = '0;
  int n_errors = 0, check_count = 0, n;
  ptp_pkg::ptp_grp_t exp_q[$];

  ptp_pipe i_dut (.clk(clk), .reset_n(reset_n), .in_valid(in_valid), .in_ready(in_ready),
    .in_grp(in_grp), .out_valid(out_valid), .out_ready(out_ready), .out_grp(out_grp),
    .scale(scale), .bias(bias), .idx_shift(idx_shift), .idx_offset(idx_offset),
    .map_color(map_color), .map_stencil(map_stencil), .need_rgba(need_rgba),
    .ctab_enable(ctab_enable), .ctab_format(ctab_format), .ctab_width(ctab_width),
    .map_log2(map_log2), .tbl_we(tbl_we), .tbl_sel(tbl_sel), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata));
  ptp_sink i_sink (.clk(clk), .reset_n(reset_n), .stall(stall), .out_ready(out_ready));

  initial forever #2.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  // entry of table t, lane k, address a: unique so a wrong address shows
  function automatic logic [15:0] tv(int t, int k, int a);
    return {2'h0, 4'(t), 2'(k), 8'(a)};
  endfunction : tv
  function automatic int ca(logic [15:0] v, int m);
    int c;
    c = $signed(v);
    c = c < 0 ? 0 : c > 4096 ? 4096 : c;
    return (c * m + 2048) >> 12;
  endfunction : ca
  function automatic int ia(logic [23:0] x, int n);
    return ((int'(x) + 128) >> 8) & ((1 << n) - 1);
  endfunction : ia
  // -1: channel kept
  function automatic int slot(ptp_pkg::ptp_fmt_t f, int k);
    case (f)
      ptp_pkg::FMT_ALPHA: return k == 3 ? 3 : -1;
      ptp_pkg::FMT_LUM: return k == 3 ? -1 : 0;
      ptp_pkg::FMT_LUM_ALPHA: return k == 3 ? 3 : 0;
      ptp_pkg::FMT_INTENS: return 0;
      ptp_pkg::FMT_RGB: return k == 3 ? -1 : k;
      default: return k;
    endcase
  endfunction : slot
  function automatic ptp_pkg::ptp_grp_t ref_grp(ptp_pkg::ptp_grp_t r);
    logic signed [31:0] p;
    logic [23:0] x;
    int s;
    for (int k = 0; k < 4; k++) begin
      s = r.kind == ptp_pkg::K_FCOL ? k : 4;
      if (s == k || (k == 0 && r.kind inside {ptp_pkg::K_DEPTH, ptp_pkg::K_DS})) begin
        p = ($signed(r.c[k]) * $signed(scale[s])) >>> 12;
        p = p + $signed(bias[s]);
        r.c[k] = p > 32767 ? 16'h7fff : p < -32768 ? 16'h8000 : p[15:0];
      end
    end
    if (r.kind inside {ptp_pkg::K_CIDX, ptp_pkg::K_SIDX, ptp_pkg::K_DS}) begin
      x = r.idx;
      if (r.idx_int) x[7:0] = 8'h00;
      x = idx_shift > 0 ? x << idx_shift : x >> -idx_shift;
      r.idx = x + {idx_offset, 8'h00};
    end
    if (r.kind == ptp_pkg::K_FCOL && map_color)
      for (int k = 0; k < 4; k++) r.c[k] = tv(k, 0, ca(r.c[k], (1 << map_log2[k]) - 1));
    if (r.kind == ptp_pkg::K_CIDX && need_rgba) begin
      for (int k = 0; k < 4; k++) r.c[k] = tv(4 + k, 0, ia(r.idx, map_log2[4 + k]));
      r.kind = ptp_pkg::K_FCOL;
    end else if (r.kind == ptp_pkg::K_CIDX && map_color) begin
      r.idx = {tv(8, 0, ia(r.idx, map_log2[8])), 8'h00};
    end
    if (r.kind inside {ptp_pkg::K_SIDX, ptp_pkg::K_DS} && map_stencil)
      r.idx = {tv(9, 0, r.idx[23:8] & ((1 << map_log2[9]) - 1)), 8'h00};
    if (r.kind == ptp_pkg::K_FCOL && ctab_enable && ctab_width != 0)
      for (int k = 0; k < 4; k++)
        if (slot(ctab_format, k) >= 0)
          r.c[k] = tv(10, slot(ctab_format, k), ca(r.c[k], ctab_width - 1));
    return r;
  endfunction : ref_grp
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [95:0] seen, logic [95:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  function automatic ptp_pkg::ptp_grp_t rg(ptp_pkg::ptp_kind_t k);
    ptp_pkg::ptp_grp_t r;
    r.kind = k;
    r.idx_int = 1'($urandom_range(0, 1));
    r.idx = 24'($urandom);
    // spans below zero and above one so clamps are hit
    for (int i = 0; i < 4; i++) r.c[i] = 16'($urandom_range(0, 16'h1800) - 16'h0400);
    return r;
  endfunction : rg
  task automatic load_all;
    for (int t = 0; t < 11; t++)
      for (int a = 0; a < 256; a++) begin
        @(negedge clk);
        tbl_we = 1'h1;
        tbl_sel = 4'(t);
        tbl_addr = 8'(a);
        tbl_wdata = {tv(t, 3, a), tv(t, 2, a), tv(t, 1, a), tv(t, 0, a)};
      end
    @(negedge clk);
    tbl_we = 1'h0;
  endtask : load_all
  task automatic cfg(logic [3:0] f, ptp_pkg::ptp_fmt_t fm, logic [8:0] w);
    @(negedge clk);
    {map_color, map_stencil, need_rgba, ctab_enable} = f;
    ctab_format = fm;
    ctab_width = w;
    idx_shift = 6'($urandom_range(0, 12) - 6);
    idx_offset = 16'($urandom_range(0, 16'h00ff) - 16'h0080);
    for (int i = 0; i < 5; i++) begin
      scale[i] = 16'($urandom_range(0, 16'h3000) - 16'h1000);
      bias[i] = 16'($urandom_range(0, 16'h1000) - 16'h0800);
    end
    for (int i = 0; i < 10; i++) map_log2[i] = 4'($urandom_range(1, 8));
    // enable goes through a state bit, give it time to land
    repeat (2) @(negedge clk);
  endtask : cfg
  task automatic send(ptp_pkg::ptp_grp_t s);
    @(negedge clk);
    in_valid = 1'h1;
    in_grp = s;
    while (!in_ready) @(negedge clk);
    @(posedge clk);
    exp_q.push_back(ref_grp(s));
  endtask : send
  task automatic batch(int cnt);
    int w;
    for (int i = 0; i < cnt; i++) send(rg(ptp_pkg::ptp_kind_t'($urandom_range(0, 5))));
    @(negedge clk);
    in_valid = 1'h0;
    for (w = 0; w < 500 && exp_q.size() != 0; w++) @(negedge clk);
    check("drain", exp_q.size(), 0);
    repeat (3) @(negedge clk);
  endtask : batch
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset_n && out_valid === 1'h1 && out_ready === 1'h1) begin
      if (exp_q.size() == 0) begin
        check("spare group", 1, 0);
      end else begin
        g = exp_q.pop_front();
        check("group", {out_grp.kind, out_grp.c, out_grp.idx}, {g.kind, g.c, g.idx});
      end
    end
  end
  initial begin
    #100000;
    check("timeout", 1, 0);
    tally_and_finish();
  end
  initial begin
    void'($urandom(55));
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'h1;
    load_all();
    stall = 2'h1;
    cfg(4'h0, ptp_pkg::FMT_RGBA, 9'h000);
    batch(40);
    cfg(4'h8, ptp_pkg::FMT_RGBA, 9'h000);
    // unity depth gain and no index shift, so the pass-through checks get exercised
    scale[4] = 16'h1000;
    bias[4] = 16'h0000;
    idx_shift = 6'h00;
    batch(40);
    cfg(4'h6, ptp_pkg::FMT_RGBA, 9'h000);
    batch(40);
    for (int f = 0; f < 6; f++) begin
      cfg(4'h1, ptp_pkg::ptp_fmt_t'(f), 9'($urandom_range(1, 256)));
      batch(25);
    end
    // zero-width table enabled, and the widest right shift
    cfg(4'hf, ptp_pkg::FMT_RGBA, 9'h000);
    idx_shift = 6'h20;
    batch(25);
    cfg(4'h7, ptp_pkg::FMT_LUM_ALPHA, 9'h100);
    batch(25);
    // far side stalls until the pipe refuses, then drains
    stall = 2'h3;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (!in_ready) break;
      in_valid = 1'h1;
      in_grp = rg(ptp_pkg::K_FCOL);
      @(posedge clk);
      exp_q.push_back(in_grp);
    end
    in_valid = 1'h0;
    check("fill", n, 10);
    // head group already passed the table; the rest meet the dropped enable bit
    exp_q[0] = ref_grp(exp_q[0]);
    ctab_enable = 1'h0;
    for (int i = 1; i < exp_q.size(); i++) exp_q[i] = ref_grp(exp_q[i]);
    // release right behind the drop so stage two loads on the second rising edge after it
    @(posedge clk);
    stall = 2'h0;
    batch(0);
    tally_and_finish();
  end
endmodule : pixel_transfer_pipeline_test
